//--- core/vfdsl_core.v
`timescale 1ns/10ps
`default_nettype none
`include "vfdsl_map.vh"

module vfdsl_core #(
  parameter LINES = `VFDSL_LINES,
  parameter ADDR_W = 8
) (
  input wire aclk,
  input wire aresetn,
  input wire shift_clk,
  input wire serial_input,
  input wire latch_strobe,
  input wire blank_n,
  input wire force_lit,
  output wire serial_carry,
  output reg [LINES-1:0] drive_line,
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready
);

  // Pin handling overview
  // Host pins carry no timing relation to aclk
  // Shift clock is sampled as data, never used as a clock
  // Trade-off: one clock domain, but a slow host link
  // Each pin level must hold two aclk periods or more
  // Shorter pulses may vanish inside the filter
  // Display events land about five edges after their pin
  // Serial data must settle before its shift clock rises
  // Host keeps that order since all pins lag alike
  // Bus side needs no crossing, it already runs on aclk
  // Limitation: no event is seen while aresetn is low
  // Pins must be idle low while reset is applied

  // Synchronised pins
  wire [`VFDSL_PIN_COUNT-1:0] pin_raw; // Raw pin vector
  wire [`VFDSL_PIN_COUNT-1:0] pin_lvl; // Filtered levels
  wire [`VFDSL_PIN_COUNT-1:0] pin_rise; // Filtered rising pulses

  // Display state
  // Stage 1 sits in bit 0, so a shift is one concatenation
  // All of it powers up clear under aresetn
  reg [LINES-1:0] shift_stage_r; // Serial shift chain, bit 0 is stage 1
  reg [LINES-1:0] shift_stage_nxt; // Next chain value
  reg [LINES-1:0] latched_bit_r; // Parallel latch
  reg [LINES-1:0] latched_bit_nxt; // Next latch value
  reg [LINES-1:0] drive_nxt; // Next driver pattern

  // Register map in brief
  // Control word: bit 0 software blank, read and write
  // Pin word: filtered pin levels, read only
  // Latch and chain: two words each, read only
  // Upper words carry the top positions in their low bits

  // Software control
  // Reset leaves software blank off, so pins alone decide
  reg soft_blank_r; // Extra blanking from software

  // Register bus user side
  // Write fields come straight from slave flops
  // They stay valid after the pulse until the next write
  wire wr_en; // One-cycle write pulse
  wire [ADDR_W-1:0] wr_addr; // Write address
  wire [31:0] wr_data; // Write data
  wire [3:0] wr_strb; // Write byte lanes
  reg wr_err; // Unmapped or read-only write
  reg [31:0] rd_data; // Read mux output
  reg rd_err; // Unmapped read

  // Convenience names for the filtered pins
  // Only filtered levels and pulses are used past here
  // Raw pins must never reach the display logic
  wire sck_rise = pin_rise[`VFDSL_PIN_SCK];
  wire din_lvl = pin_lvl[`VFDSL_PIN_DIN];
  wire ls_lvl = pin_lvl[`VFDSL_PIN_LS];
  wire ls_rise = pin_rise[`VFDSL_PIN_LS];
  wire blank_lvl = pin_lvl[`VFDSL_PIN_BLANK];
  wire force_lvl = pin_lvl[`VFDSL_PIN_FORCE];

  // Clear event: shift clock rises with strobe high
  // The strobe level, not its edge, qualifies a clear
  // Strobe must be high some cycles before the clock rises
  // Same filtered pulse as a shift, so no race between them
  wire clear_evt = sck_rise & ls_lvl;

  // Output pattern for a given latch and control levels
  // Priority: blank, then force, then latch data
  // Blank wins so the panel can always be darkened
  function [LINES-1:0] drive_of;
    input [LINES-1:0] latch;
    input unblank;
    input force_on;
    begin
      if (!unblank) begin
        drive_of = {LINES{1'b0}};
      end else if (force_on) begin
        drive_of = {LINES{1'b1}};
      end else begin
        drive_of = latch;
      end
    end
  endfunction

  // Lower word of a wide vector for the read mux
  // Shared by the latch and chain reads
  function [31:0] lo_word;
    input [LINES-1:0] v;
    begin
      lo_word = v[31:0];
    end
  endfunction

  // Upper bits of a wide vector, zero padded
  // Limitation: LINES must stay between 33 and 63
  function [31:0] hi_word;
    input [LINES-1:0] v;
    begin
      hi_word = {{(64 - LINES){1'b0}}, v[LINES-1:32]};
    end
  endfunction

  // Pin order fixed by the map
  // A wrong order here swaps pins without any error
  assign pin_raw = {force_lit, blank_n, latch_strobe, serial_input, shift_clk};

  // Pins come from the host domain and need the filter
  // One filter for all pins keeps their lags equal
  // Equal lags keep data ahead of its shift clock edge
  // Reset clears all stages; idle low pins then give no false edge
  vfdsl_pin_sync #(
    .WIDTH(`VFDSL_PIN_COUNT)
  ) u_pin_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin_in(pin_raw),
    .level_r(pin_lvl),
    .rise_r(pin_rise)
  );

  // Shift chain next state
  // Clear has priority over shifting
  // Without a filtered clock pulse the chain holds
  always @* begin
    // Default is to hold
    shift_stage_nxt = shift_stage_r;
    if (clear_evt) begin
      shift_stage_nxt = {LINES{1'b0}};
    end else if (sck_rise) begin
      // New bit enters stage 1, others move toward the end
      shift_stage_nxt = {shift_stage_r[LINES-2:0], din_lvl};
    end
  end

  // Latch next state; a clear beats a strobe rise
  // A strobe rise copies the chain as it stood before the edge
  // Falling strobe edges leave the latch alone
  always @* begin
    latched_bit_nxt = latched_bit_r;
    if (clear_evt) begin
      latched_bit_nxt = {LINES{1'b0}};
    end else if (ls_rise) begin
      latched_bit_nxt = shift_stage_r;
    end
  end

  // Drivers follow the new latch value, so a clear lands at once
  // Software blank joins the pin blank and also beats force
  // Trade-off: one more gate level ahead of the driver flops
  always @* begin
    drive_nxt = drive_of(latched_bit_nxt, blank_lvl & ~soft_blank_r, force_lvl);
  end

  // Display state registers
  // Reset values match a blanked, cleared panel
  always @(posedge aclk) begin
    if (!aresetn) begin
      // Blank until the host clears and loads
      shift_stage_r <= {LINES{1'b0}};
      latched_bit_r <= {LINES{1'b0}};
      drive_line <= {LINES{1'b0}};
    end else begin
      // Every register takes its next value on every edge
      shift_stage_r <= shift_stage_nxt;
      latched_bit_r <= latched_bit_nxt;
      drive_line <= drive_nxt;
    end
  end

  // Carry is the last stage, already a flop
  // It moves only when the chain moves
  // A chained driver sees it one filter lag after the clock
  assign serial_carry = shift_stage_r[LINES-1];

  // Writable control bits
  // Only byte lane zero holds a control bit
  // Rejected writes leave the bit alone
  always @(posedge aclk) begin
    if (!aresetn) begin
      soft_blank_r <= `VFDSL_CTRL_RESET;
    end else if (wr_en && !wr_err && wr_strb[0]) begin
      soft_blank_r <= wr_data[`VFDSL_CTRL_SOFT_BLANK];
    end
  end

  // Only the control word takes writes
  // Every other offset is read-only or unmapped
  // Kept combinational; the slave samples it at commit
  always @* begin
    wr_err = (wr_addr != `VFDSL_OFS_CTRL);
  end

  // Read mux; unmapped offsets answer with an error
  // Reads have no side effects on display state
  // Latch and chain are read as they stand, not resampled
  always @* begin
    rd_err = 1'b0;
    rd_data = 32'h00000000;
    case (s_axi_araddr)
      `VFDSL_OFS_CTRL: begin
        rd_data = {31'h0, soft_blank_r};
      end
      `VFDSL_OFS_PINS: begin
        // Filtered pin levels as the core sees them
        rd_data = {27'h0, pin_lvl};
      end
      `VFDSL_OFS_LATCH_LO: begin
        // Positions 1 to 32
        rd_data = lo_word(latched_bit_r);
      end
      `VFDSL_OFS_LATCH_HI: begin
        // Top positions in the low bits
        rd_data = hi_word(latched_bit_r);
      end
      `VFDSL_OFS_SHIFT_LO: begin
        // Stages 1 to 32
        rd_data = lo_word(shift_stage_r);
      end
      `VFDSL_OFS_SHIFT_HI: begin
        // Top stages in the low bits
        rd_data = hi_word(shift_stage_r);
      end
      default: begin
        // Data stays zero on an error
        rd_err = 1'b1;
      end
    endcase
  end

  // Bus slave; all its outputs are flops
  // Same clock as the display logic, so no crossing
  // One write and one read may be in flight at once
  // Write pulse lasts one cycle; address and data hold after it
  vfdsl_axil_slave #(
    .ADDR_W(ADDR_W)
  ) u_axil (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_en_r(wr_en),
    .wr_addr_r(wr_addr),
    .wr_data_r(wr_data),
    .wr_strb_r(wr_strb),
    .wr_err(wr_err),
    .rd_data(rd_data),
    .rd_err(rd_err)
  );

endmodule

`default_nettype wire

//--- core/vfdsl_map.vh
`ifndef VFDSL_MAP_VH
`define VFDSL_MAP_VH

// Display geometry
`define VFDSL_LINES 60
`define VFDSL_HI_BITS 28

// Pin vector positions after synchronising
`define VFDSL_PIN_SCK 0
`define VFDSL_PIN_DIN 1
`define VFDSL_PIN_LS 2
`define VFDSL_PIN_BLANK 3
`define VFDSL_PIN_FORCE 4
`define VFDSL_PIN_COUNT 5

// Register byte offsets
`define VFDSL_OFS_CTRL 8'h00
`define VFDSL_OFS_PINS 8'h04
`define VFDSL_OFS_LATCH_LO 8'h08
`define VFDSL_OFS_LATCH_HI 8'h0C
`define VFDSL_OFS_SHIFT_LO 8'h10
`define VFDSL_OFS_SHIFT_HI 8'h14

// Control fields and reset values
`define VFDSL_CTRL_SOFT_BLANK 0
`define VFDSL_CTRL_RESET 1'h0

// Bus answers
`define VFDSL_RESP_OKAY 2'h0
`define VFDSL_RESP_SLVERR 2'h2

`endif

//--- core/vfdsl_pin_sync.v
`timescale 1ns/10ps
`default_nettype none

// Three-stage synchroniser with agreement filter per pin
module vfdsl_pin_sync #(
  parameter WIDTH = 5
) (
  input wire aclk,
  input wire aresetn,
  input wire [WIDTH-1:0] pin_in,
  output reg [WIDTH-1:0] level_r,
  output reg [WIDTH-1:0] rise_r
);

  reg [WIDTH-1:0] stage1_r; // Metastability catcher, read by stage2 only
  reg [WIDTH-1:0] stage2_r; // Second stage
  reg [WIDTH-1:0] stage3_r; // Third stage
  wire [WIDTH-1:0] agree; // Stages two and three agree
  wire [WIDTH-1:0] level_nxt; // Filtered level next value

  assign agree = ~(stage2_r ^ stage3_r);
  // A change only counts once two and three agree
  assign level_nxt = (agree & stage2_r) | (~agree & level_r);

  // Pipeline and filtered level
  always @(posedge aclk) begin
    if (!aresetn) begin
      stage1_r <= {WIDTH{1'b0}};
      stage2_r <= {WIDTH{1'b0}};
      stage3_r <= {WIDTH{1'b0}};
      level_r <= {WIDTH{1'b0}};
      rise_r <= {WIDTH{1'b0}};
    end else begin
      stage1_r <= pin_in;
      stage2_r <= stage1_r;
      stage3_r <= stage2_r;
      level_r <= level_nxt;
      rise_r <= level_nxt & ~level_r; // One-cycle rising pulse
    end
  end

endmodule

`default_nettype wire

//--- core/vfdsl_axil_slave.v
`timescale 1ns/10ps
`default_nettype none

// AXI4-Lite slave: one write and one read in flight
module vfdsl_axil_slave #(
  parameter ADDR_W = 8
) (
  input wire aclk,
  input wire aresetn,
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg wr_en_r,
  output reg [ADDR_W-1:0] wr_addr_r,
  output reg [31:0] wr_data_r,
  output reg [3:0] wr_strb_r,
  input wire wr_err,
  input wire [31:0] rd_data,
  input wire rd_err
);

  reg aw_held_r; // Write address captured
  reg w_held_r; // Write data captured
  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take = s_axi_wvalid & s_axi_wready;
  wire b_done = s_axi_bvalid & s_axi_bready;
  wire commit = aw_held_r & w_held_r & ~s_axi_bvalid;
  wire ar_take = s_axi_arvalid & s_axi_arready;
  wire r_done = s_axi_rvalid & s_axi_rready;
  wire aw_held_nxt = ~commit & (aw_held_r | aw_take);
  wire w_held_nxt = ~commit & (w_held_r | w_take);
  wire bvalid_nxt = commit | (s_axi_bvalid & ~b_done);
  wire rvalid_nxt = ar_take | (s_axi_rvalid & ~r_done);

  // Write path; address and data taken in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `VFDSL_RESP_OKAY;
      wr_en_r <= 1'b0;
      wr_addr_r <= {ADDR_W{1'b0}};
      wr_data_r <= 32'h00000000;
      wr_strb_r <= 4'h0;
    end else begin
      aw_held_r <= aw_held_nxt;
      w_held_r <= w_held_nxt;
      // Readies drop until the response is taken
      s_axi_awready <= ~aw_held_nxt & ~bvalid_nxt;
      s_axi_wready <= ~w_held_nxt & ~bvalid_nxt;
      s_axi_bvalid <= bvalid_nxt;
      wr_en_r <= commit;
      if (aw_take) begin
        wr_addr_r <= s_axi_awaddr;
      end
      if (w_take) begin
        wr_data_r <= s_axi_wdata;
        wr_strb_r <= s_axi_wstrb;
      end
      if (commit) begin
        s_axi_bresp <= wr_err ? `VFDSL_RESP_SLVERR : `VFDSL_RESP_OKAY;
      end
    end
  end

  // Read path; data captured at the address handshake
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `VFDSL_RESP_OKAY;
    end else begin
      s_axi_arready <= ~rvalid_nxt;
      s_axi_rvalid <= rvalid_nxt;
      if (ar_take) begin
        s_axi_rdata <= rd_err ? 32'h00000000 : rd_data;
        s_axi_rresp <= rd_err ? `VFDSL_RESP_SLVERR : `VFDSL_RESP_OKAY;
      end
    end
  end

endmodule

`default_nettype wire

//--- verif/vfdsl_core_chk.sv
`timescale 1ns/10ps
`default_nettype none
// Port checks; pin filter lag is about five cycles
module vfdsl_core_chk #(
  parameter LINES = 60
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic shift_clk,
  input wire logic latch_strobe,
  input wire logic blank_n,
  input wire logic force_lit,
  input wire logic serial_carry,
  input wire logic [LINES-1:0] drive_line,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready
);
  logic [3:0] bf_cnt; // Quiet cycles of blank and force
  logic [3:0] ls_cnt; // Same, strobe included
  logic [3:0] ck_cnt; // Quiet cycles of shift clock
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Saturating counters, so long gaps never wrap
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bf_cnt <= 4'h0;
      ls_cnt <= 4'h0;
      ck_cnt <= 4'h0;
    end else begin
      bf_cnt <= ($changed(blank_n) || $changed(force_lit)) ? 4'h0 : bf_cnt + {3'h0, bf_cnt != 4'hF};
      ls_cnt <= ($changed(blank_n) || $changed(force_lit) || $changed(latch_strobe)) ? 4'h0 :
        ls_cnt + {3'h0, ls_cnt != 4'hF};
      ck_cnt <= $changed(shift_clk) ? 4'h0 : ck_cnt + {3'h0, ck_cnt != 4'hF};
    end
  end
  // Counters clear one edge after a change, so a change seen now is excluded too
  blank_low_a: assert property (bf_cnt >= 4'h8 && !$changed(blank_n) && !$changed(force_lit) && !blank_n
    |-> ~|drive_line)
    else $error("drivers not low while blanked");
  force_high_a: assert property (bf_cnt >= 4'h8 && !$changed(blank_n) && !$changed(force_lit) && blank_n
    && force_lit |-> &drive_line)
    else $error("drivers not high while forced");
  clear_all_a: assert property ($rose(shift_clk) && latch_strobe && $past(latch_strobe, 4) && !force_lit
    && bf_cnt >= 4'h8 |-> ##[4:8] (!serial_carry && ~|drive_line))
    else $error("clear edge left bits set");
  carry_hold_a: assert property (ck_cnt >= 4'h8 |-> $stable(serial_carry))
    else $error("carry moved without a clock edge");
  latch_hold_a: assert property (ls_cnt >= 4'h8 && !latch_strobe |-> $stable(drive_line))
    else $error("drivers moved without a strobe");
  shift_quiet_a: assert property ($rose(shift_clk) && !latch_strobe && ls_cnt >= 4'h8
    |-> ##1 $stable(drive_line) [*7])
    else $error("shifting disturbed the drivers");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  wr_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer not retired");
  clear_c: cover property ($rose(shift_clk) && latch_strobe);
  force_c: cover property (blank_n && force_lit && &drive_line);
  read_c: cover property (s_axi_arvalid && s_axi_arready);
endmodule
bind vfdsl_core vfdsl_core_chk #(.LINES(LINES)) chk_u (.aclk(aclk), .aresetn(aresetn), .shift_clk(shift_clk),
  .latch_strobe(latch_strobe), .blank_n(blank_n), .force_lit(force_lit), .serial_carry(serial_carry),
  .drive_line(drive_line), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready));
`default_nettype wire

//--- verif/vfdsl_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// Host side of the serial pins
module vfdsl_host_model (
  input wire logic aclk,
  output var logic shift_clk,
  output var logic serial_input,
  output var logic latch_strobe,
  output var logic blank_n,
  output var logic force_lit
);
  // Power-up levels; blank stays low until data is in
  initial begin
    shift_clk = 1'b0;
    serial_input = 1'b0;
    latch_strobe = 1'b0;
    force_lit = 1'b0;
    blank_n = 1'b0;
  end
  // Moves land just after an edge
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // One bit; data turns over once its hold is done
  task automatic send_bit(input logic b);
    serial_input <= b;
    wait_cyc(2);
    shift_clk <= 1'b1;
    wait_cyc(5);
    serial_input <= ~b;
    shift_clk <= 1'b0;
    wait_cyc(5);
  endtask
  // Strobe pulse; a clock rise inside it clears
  task automatic strobe(input logic clr);
    latch_strobe <= 1'b1;
    wait_cyc(6);
    if (clr) send_bit(1'b1);
    latch_strobe <= 1'b0;
    wait_cyc(6);
  endtask
  // Blank and force together, then settle
  task automatic set_ctl(input logic bl, input logic fl);
    blank_n <= bl;
    force_lit <= fl;
    wait_cyc(8);
  endtask
endmodule
`default_nettype wire

//--- verif/vfdsl_core_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "vfdsl_map.vh"
// Scoreboard bench for the display driver
module vfdsl_core_tb_top;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  wire shift_clk, serial_input, latch_strobe, blank_n, force_lit, serial_carry;
  wire [59:0] drive_line;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  wire awready, wready, bvalid, arready, rvalid;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  logic [60:0] exp_q[$]; // Carry and drivers to expect
  logic [33:0] rd_q[$]; // Response and read data
  logic [59:0] sh = 60'h0, lat = 60'h0; // Reference stages and latch
  logic bl = 1'b0, fl = 1'b0; // Reference blank and force
  logic [7:0] lfsr = 8'h27; // Seed 39
  int mismatches = 0, cmp_count = 0, i;
  event sample_ev;
  always #25 aclk = ~aclk;
  vfdsl_host_model host_u (.aclk(aclk), .shift_clk(shift_clk), .serial_input(serial_input),
    .latch_strobe(latch_strobe), .blank_n(blank_n), .force_lit(force_lit));
  vfdsl_core dut_u (.aclk(aclk), .aresetn(aresetn), .shift_clk(shift_clk), .serial_input(serial_input),
    .latch_strobe(latch_strobe), .blank_n(blank_n), .force_lit(force_lit), .serial_carry(serial_carry),
    .drive_line(drive_line), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    if (mismatches == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Bounded waits end the run when spent
  task automatic hang(input int n);
    if (n == 50) begin
      mismatches++;
      finish_test();
    end
  endtask
  // Write; address and data offered together
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    hang(n);
    check(bresp, er);
    bready <= 1'b0;
    @(posedge aclk);
  endtask
  // Read; the answer is judged by the monitor
  task automatic axi_rd(input logic [7:0] a, input logic [33:0] e);
    int n;
    rd_q.push_back(e);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    hang(n);
    rready <= 1'b0;
    @(posedge aclk);
  endtask
  // Note the expected pins, then sample off the edge
  task automatic note_pins();
    exp_q.push_back({sh[59], !bl ? 60'h0 : fl ? {60{1'b1}} : lat});
    @(negedge aclk);
    -> sample_ev;
    @(posedge aclk);
  endtask
  // Random bit into the reference and the pins
  task automatic shift_one();
    lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    sh = {sh[58:0], lfsr[0]};
    host_u.send_bit(lfsr[0]);
    note_pins();
  endtask
  // Pins against the oldest note
  always @(sample_ev) begin
    if (exp_q.size() > 0) check({serial_carry, drive_line}, exp_q.pop_front());
  end
  // Read answers against the oldest note
  always @(posedge aclk) begin
    if (rvalid === 1'b1 && rready === 1'b1 && rd_q.size() > 0) check({rresp, rdata}, rd_q.pop_front());
  end
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    host_u.strobe(1'b1);
    note_pins();
    for (i = 0; i < 60; i++) shift_one();
    axi_rd(`VFDSL_OFS_SHIFT_LO, {2'h0, sh[31:0]});
    axi_rd(`VFDSL_OFS_SHIFT_HI, {6'h00, sh[59:32]});
    axi_rd(`VFDSL_OFS_LATCH_LO, 34'h0);
    host_u.strobe(1'b0);
    lat = sh;
    axi_rd(`VFDSL_OFS_LATCH_HI, {6'h00, lat[59:32]});
    bl = 1'b1;
    host_u.set_ctl(1'b1, 1'b0);
    note_pins();
    for (i = 0; i < 5; i++) shift_one();
    fl = 1'b1;
    host_u.set_ctl(1'b1, 1'b1);
    note_pins();
    bl = 1'b0;
    host_u.set_ctl(1'b0, 1'b1);
    note_pins();
    axi_wr(`VFDSL_OFS_CTRL, 32'h1, `VFDSL_RESP_OKAY);
    axi_rd(`VFDSL_OFS_CTRL, 34'h1);
    axi_wr(`VFDSL_OFS_CTRL, 32'h0, `VFDSL_RESP_OKAY);
    axi_wr(8'h20, 32'h1, `VFDSL_RESP_SLVERR);
    axi_rd(8'h20, {`VFDSL_RESP_SLVERR, 32'h0});
    bl = 1'b1;
    fl = 1'b0;
    host_u.set_ctl(1'b1, 1'b0);
    note_pins();
    axi_rd(`VFDSL_OFS_PINS, {32'h00000002, ~lfsr[0], 1'b0});
    host_u.strobe(1'b1);
    sh = 60'h0;
    lat = 60'h0;
    note_pins();
    axi_rd(`VFDSL_OFS_SHIFT_HI, 34'h0);
    axi_rd(`VFDSL_OFS_LATCH_LO, 34'h0);
    finish_test();
  end
endmodule
`default_nettype wire
